/* File: inc/fbp_pkg.sv */
// package of constants for the feedback packet assembler
// assumes a single clock domain and no imports by its users
//
// Operation
// - feedback only answers endpoint 1 IN requests
// - packet never longer than 32 bytes
// - sixteen state bytes always lead packet
// - zero to sixteen result bytes follow
// - short packet when under 32, never zero length
// - push result on command error or attach
// - detect byte distinct, host scans for it
// - byte 0 carries three enable flags
// - bytes 1 to 6 mirror current settings
// - byte 8 carries six live status flags
// - bytes 9,10 active command, zero idle
// - bytes 11 to 13 buffer fill counts
// - test bytes 14,15, results from 16
package fbp_pkg;
  // ****************************************
  // packet layout
  // ****************************************
  localparam int unsigned STATE_BYTES   = 16;              // state section length
  localparam int unsigned RESULT_BYTES  = 16;              // result section maximum
  localparam int unsigned PACKET_MAX    = 32;              // whole packet maximum
  localparam logic [4:0]  OFS_ENABLE    = 5'h00;           // enable_flags
  localparam logic [4:0]  OFS_SPEED     = 5'h01;           // bus_speed_code
  localparam logic [4:0]  OFS_PULLDUR   = 5'h02;           // pullup_duration
  localparam logic [4:0]  OFS_PROGDUR   = 5'h03;           // program_pulse_duration
  localparam logic [4:0]  OFS_SLEW      = 5'h04;           // pulldown_slew_code
  localparam logic [4:0]  OFS_W1LOW     = 5'h05;           // write_one_low_time
  localparam logic [4:0]  OFS_SAMPLE    = 5'h06;           // sample_offset_recovery
  localparam logic [4:0]  OFS_TEST_A    = 5'h07;           // test_reserved_a
  localparam logic [4:0]  OFS_STATUS    = 5'h08;           // device_status_flags
  localparam logic [4:0]  OFS_CMD_LO    = 5'h09;           // active_command_low
  localparam logic [4:0]  OFS_CMD_HI    = 5'h0A;           // active_command_high
  localparam logic [4:0]  OFS_CMDFILL   = 5'h0B;           // command buffer fill
  localparam logic [4:0]  OFS_WRFILL    = 5'h0C;           // write buffer fill
  localparam logic [4:0]  OFS_RDFILL    = 5'h0D;           // read buffer fill
  localparam logic [4:0]  OFS_TEST_B    = 5'h0E;           // first trailing test byte
  localparam logic [4:0]  OFS_TEST_C    = 5'h0F;           // second trailing test byte
  localparam logic [4:0]  OFS_LAST      = 5'h1F;           // last offset a packet may hold
  localparam logic [4:0]  OFS_RESULT    = 5'h10;           // first result byte
  localparam logic [7:0]  RESERVED_BYTE = 8'h00;           // reserved reads zero
  localparam logic [3:0]  FEEDBACK_EP   = 4'h1;            // feedback endpoint
endpackage

/* File: rtl/fbp_feedback.sv */
// feedback packet assembler: answers IN requests with state then result bytes
// assumes a usb core that raises in_req for one cycle per IN token, takes one
// byte per tx_ready cycle while tx_valid, and ends the packet on tx_last
// assumes every pin input is synchronous to clk_sys and reset is asynchronous
// the result buffer holds DEPTH entries; pushes beyond that are dropped
`timescale 1ns/1ns
`default_nettype none
module fbp_feedback #(
  parameter int unsigned DEPTH = 16                 // result buffer entries
) (
  input  wire logic       clk_sys,                  // 20 MHz system clock
  input  wire logic       reset,                    // async reset, active high
  input  wire logic       in_req,                   // IN token seen, one pulse
  input  wire logic [3:0] in_ep,                    // endpoint of the token
  input  wire logic       tx_ready,                 // core accepts a byte
  output logic            tx_valid,                 // byte on tx_data is valid
  output logic [7:0]      tx_data,                  // packet byte
  output logic            tx_last,                  // last byte of the packet
  output logic            tx_zlp,                   // zero length answer, pulse
  input  wire logic       pullup_enable,            // enable flag bit 0
  input  wire logic       program_pulse_enable,     // enable flag bit 1
  input  wire logic       dynamic_pullup_enable,    // enable flag bit 2
  input  wire logic [7:0] bus_speed_code,           // setting byte 1
  input  wire logic [7:0] pullup_duration,          // setting byte 2
  input  wire logic [7:0] program_pulse_duration,   // setting byte 3
  input  wire logic [7:0] pulldown_slew_code,       // setting byte 4
  input  wire logic [7:0] write_one_low_time,       // setting byte 5
  input  wire logic [7:0] sample_offset_recovery,   // setting byte 6
  input  wire logic       pullup_active,            // status bit 0
  input  wire logic       program_pulse_active,     // status bit 1
  input  wire logic       high_voltage_present,     // status bit 2
  input  wire logic       external_power_mode,      // status bit 3
  input  wire logic       halted,                   // status bit 4
  input  wire logic       idle,                     // status bit 5
  input  wire logic [7:0] active_command_low,       // command byte 1
  input  wire logic [7:0] active_command_high,      // command byte 2
  input  wire logic [7:0] cmd_fill,                 // command buffer fill
  input  wire logic [7:0] write_fill,               // write buffer fill
  input  wire logic [7:0] read_fill,                // read buffer fill
  input  wire logic       result_push,              // error or attach event
  input  wire logic [7:0] result_code,              // code with result_push
  output logic [4:0]      result_count              // entries waiting
);
  localparam int unsigned AW = $clog2(DEPTH);       // pointer width

  // ****************************************
  // state machine and storage
  // ****************************************
  typedef enum logic [1:0] {FBP_IDLE, FBP_SEND} fbp_state_t;
  fbp_state_t       state_reg;                      // sender state
  logic [4:0]       pos_reg;                        // packet byte index
  logic [4:0]       len_reg;                        // packet length minus one
  logic [7:0]       mem [DEPTH];                    // result buffer
  logic [AW-1:0]    rd_reg;                         // read pointer
  logic [AW-1:0]    wr_reg;                         // write pointer
  logic [4:0]       cnt_reg;                        // entries held
  logic             tx_valid_reg;                   // output flop
  logic [7:0]       tx_data_reg;                    // output flop
  logic             tx_last_reg;                    // output flop
  logic             tx_zlp_reg;                     // output flop

  // ****************************************
  // decoding
  // ****************************************
  // state byte at a packet offset, reserved ones zero
  function automatic logic [7:0] state_byte(input logic [4:0] ofs);
    logic [7:0] b;
    b = fbp_pkg::RESERVED_BYTE;
    unique case (ofs)
      fbp_pkg::OFS_ENABLE:  b = {5'h00, dynamic_pullup_enable,
                                 program_pulse_enable, pullup_enable};
      fbp_pkg::OFS_SPEED:   b = bus_speed_code;
      fbp_pkg::OFS_PULLDUR: b = pullup_duration;
      fbp_pkg::OFS_PROGDUR: b = program_pulse_duration;
      fbp_pkg::OFS_SLEW:    b = pulldown_slew_code;
      fbp_pkg::OFS_W1LOW:   b = write_one_low_time;
      fbp_pkg::OFS_SAMPLE:  b = sample_offset_recovery;
      fbp_pkg::OFS_STATUS:  b = {2'h0, idle, halted, external_power_mode,
                                 high_voltage_present, program_pulse_active,
                                 pullup_active};
      fbp_pkg::OFS_CMD_LO:  b = idle ? 8'h00 : active_command_low;
      fbp_pkg::OFS_CMD_HI:  b = idle ? 8'h00 : active_command_high;
      fbp_pkg::OFS_CMDFILL: b = cmd_fill;
      fbp_pkg::OFS_WRFILL:  b = write_fill;
      fbp_pkg::OFS_RDFILL:  b = read_fill;
      default:              b = fbp_pkg::RESERVED_BYTE;
    endcase
    return b;
  endfunction

  wire logic       ep_hit   = in_req && (in_ep == fbp_pkg::FEEDBACK_EP);
  wire logic       take     = (state_reg == FBP_SEND) && tx_ready;        // byte leaves
  wire logic       is_res   = pos_reg[4];                                 // result area
  wire logic       pop      = take && is_res;
  wire logic       push_ok  = result_push && (cnt_reg < 5'(DEPTH));
  // result bytes in this packet, capped at sixteen
  wire logic [4:0] res_take = (cnt_reg > 5'(fbp_pkg::RESULT_BYTES)) ?
                              5'(fbp_pkg::RESULT_BYTES) : cnt_reg;
  // length minus one: 15 state bytes plus results, at most 31
  wire logic [4:0] len_next = 5'(fbp_pkg::STATE_BYTES - 1) + res_take;
  wire logic [4:0] pos_next = pos_reg + 5'h01;                            // next offset
  // state byte for the current offset; always_comb follows the inputs read
  // inside the function, which a plain assign calling it would miss
  logic [7:0]      state_now;                                             // state byte now
  always_comb begin
    state_now = state_byte(pos_reg);
  end
  wire logic [7:0] byte_next = is_res ? mem[rd_reg]
                                      : state_now;

  // ****************************************
  // sender
  // ****************************************
  // walk offsets from 0 to len; a packet under 32 ends early
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_reg <= FBP_IDLE;
      pos_reg   <= 5'h00;
      len_reg   <= 5'h00;
    end else begin
      unique case (state_reg)
        // wait for a token on the feedback endpoint
        FBP_IDLE: begin
          if (ep_hit) begin
            state_reg <= FBP_SEND;
            pos_reg   <= fbp_pkg::OFS_ENABLE;
            len_reg   <= len_next;
          end
        end
        // one byte per accepted cycle, back to idle after offset len
        FBP_SEND: begin
          if (take) begin
            pos_reg <= pos_next;
            if (pos_reg == len_reg) begin
              state_reg <= FBP_IDLE;
            end
          end
        end
      endcase
    end
  end

  // ****************************************
  // result buffer
  // ****************************************
  // pointers and count; push and pop may meet in one cycle
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= 5'h00;
    end else begin
      if (push_ok) begin
        wr_reg <= AW'(wr_reg + 1'b1);
      end
      if (pop) begin
        rd_reg <= AW'(rd_reg + 1'b1);
      end
      cnt_reg <= cnt_reg + 5'(push_ok) - 5'(pop);
    end
  end

  // storage written without reset
  always_ff @(posedge clk_sys) begin
    if (push_ok) begin
      // the detect byte is stored like any error code; its value alone marks it
      mem[wr_reg] <= result_code;
    end
  end

  // ****************************************
  // output flops
  // ****************************************
  // byte presented one cycle after the cycle in which the core takes it
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      tx_valid_reg <= 1'b0;
      tx_data_reg  <= 8'h00;
      tx_last_reg  <= 1'b0;
      tx_zlp_reg   <= 1'b0;
    end else begin
      tx_valid_reg <= take;
      tx_data_reg  <= take ? byte_next : 8'h00;
      tx_last_reg  <= take && (pos_reg == len_reg);
      tx_zlp_reg   <= 1'b0;                                               // never needed: 16 state bytes always go
    end
  end

  assign tx_valid     = tx_valid_reg;
  assign tx_data      = tx_data_reg;
  assign tx_last      = tx_last_reg;
  assign tx_zlp       = tx_zlp_reg;
  assign result_count = cnt_reg;

  // ****************************************
  // checks
  // ****************************************
  // a token for another endpoint leaves the sender idle
  property p_ep_only;
    @(posedge clk_sys) disable iff (reset)
      (state_reg == FBP_IDLE && in_req && in_ep != fbp_pkg::FEEDBACK_EP) |=> state_reg == FBP_IDLE;
  endproperty
  a_ep_only: assert property (p_ep_only) else $error("feedback sent on wrong endpoint");

  // offset 31 is always the final byte, so no packet wraps past 32
  property p_len_max;
    @(posedge clk_sys) disable iff (reset) (take && pos_reg == fbp_pkg::OFS_LAST) |-> pos_reg == len_reg;
  endproperty
  a_len_max: assert property (p_len_max) else $error("packet longer than 32");

  // the sixteen state bytes are always part of the packet
  property p_len_min;
    @(posedge clk_sys) disable iff (reset) state_reg == FBP_SEND |-> len_reg >= 5'(fbp_pkg::STATE_BYTES - 1);
  endproperty
  a_len_min: assert property (p_len_min) else $error("packet shorter than state");

  // reserved enable bits read zero, pullup enable in bit 0
  property p_first_byte;
    @(posedge clk_sys) disable iff (reset)
      (take && pos_reg == fbp_pkg::OFS_ENABLE) |=> tx_data[7:3] == 5'h00 && tx_data[0] == $past(pullup_enable);
  endproperty
  a_first_byte: assert property (p_first_byte) else $error("enable byte wrong");

  // reserved status bits read zero, idle in bit 5
  property p_status;
    @(posedge clk_sys) disable iff (reset)
      (take && pos_reg == fbp_pkg::OFS_STATUS) |=> tx_data[7:6] == 2'h0 && tx_data[5] == $past(idle);
  endproperty
  a_status: assert property (p_status) else $error("status byte wrong");

  // an idle device reports no command
  property p_cmd_idle;
    @(posedge clk_sys) disable iff (reset)
      (take && idle && (pos_reg == fbp_pkg::OFS_CMD_LO || pos_reg == fbp_pkg::OFS_CMD_HI)) |=> tx_data == 8'h00;
  endproperty
  a_cmd_idle: assert property (p_cmd_idle) else $error("command byte not zero when idle");

  // test bytes always read zero
  property p_test_zero;
    @(posedge clk_sys) disable iff (reset)
      (take && (pos_reg == fbp_pkg::OFS_TEST_A || pos_reg == fbp_pkg::OFS_TEST_B ||
                pos_reg == fbp_pkg::OFS_TEST_C)) |=> tx_data == 8'h00;
  endproperty
  a_test_zero: assert property (p_test_zero) else $error("test byte not zero");

  // the final byte carries the end mark and the next cycle is empty
  property p_last;
    @(posedge clk_sys) disable iff (reset)
      (take && pos_reg == len_reg) |=> tx_last ##1 !tx_valid;
  endproperty
  a_last: assert property (p_last) else $error("packet end missing");

  // a result byte sent leaves the buffer
  property p_pop;
    @(posedge clk_sys) disable iff (reset)
      (pop && !push_ok) |=> cnt_reg == $past(cnt_reg) - 5'h01;
  endproperty
  a_pop: assert property (p_pop) else $error("sent result not removed");

  // an accepted event adds one entry
  property p_push;
    @(posedge clk_sys) disable iff (reset)
      (push_ok && !pop) |=> cnt_reg == $past(cnt_reg) + 5'h01;
  endproperty
  a_push: assert property (p_push) else $error("result not stored");

  // a token taken while idle opens a packet at offset zero
  property p_new_packet;
    @(posedge clk_sys) disable iff (reset)
      (state_reg == FBP_IDLE && ep_hit) |=> state_reg == FBP_SEND && pos_reg == fbp_pkg::OFS_ENABLE;
  endproperty
  a_new_packet: assert property (p_new_packet) else $error("packet does not start at offset zero");

  // all three enable flags in their bit places
  property p_enable_bits;
    @(posedge clk_sys) disable iff (reset)
      (take && pos_reg == fbp_pkg::OFS_ENABLE) |=> tx_data[2:0] == {$past(dynamic_pullup_enable),
                                                    $past(program_pulse_enable), $past(pullup_enable)};
  endproperty
  a_enable_bits: assert property (p_enable_bits) else $error("enable flags misplaced");

  // speed code mirrored as it stands
  property p_speed;
    @(posedge clk_sys) disable iff (reset)
      (take && pos_reg == fbp_pkg::OFS_SPEED) |=> tx_data == $past(bus_speed_code);
  endproperty
  a_speed: assert property (p_speed) else $error("speed code not mirrored");

  // last setting byte mirrored as it stands
  property p_sample;
    @(posedge clk_sys) disable iff (reset)
      (take && pos_reg == fbp_pkg::OFS_SAMPLE) |=> tx_data == $past(sample_offset_recovery);
  endproperty
  a_sample: assert property (p_sample) else $error("sample offset not mirrored");

  // live status flags in their bit places
  property p_status_bits;
    @(posedge clk_sys) disable iff (reset)
      (take && pos_reg == fbp_pkg::OFS_STATUS) |=> tx_data[4:0] == {$past(halted), $past(external_power_mode),
                              $past(high_voltage_present), $past(program_pulse_active), $past(pullup_active)};
  endproperty
  a_status_bits: assert property (p_status_bits) else $error("status flags misplaced");

  // a busy device reports the high byte of the command it runs
  property p_cmd_busy;
    @(posedge clk_sys) disable iff (reset)
      (take && !idle && pos_reg == fbp_pkg::OFS_CMD_HI) |=> tx_data == $past(active_command_high);
  endproperty
  a_cmd_busy: assert property (p_cmd_busy) else $error("running command not reported");

  // read buffer fill passed through
  property p_fills;
    @(posedge clk_sys) disable iff (reset)
      (take && pos_reg == fbp_pkg::OFS_RDFILL) |=> tx_data == $past(read_fill);
  endproperty
  a_fills: assert property (p_fills) else $error("fill count not reported");

  // a push into a full buffer is dropped
  property p_full_drop;
    @(posedge clk_sys) disable iff (reset)
      (result_push && cnt_reg == 5'(DEPTH) && !pop) |=> cnt_reg == 5'(DEPTH);
  endproperty
  a_full_drop: assert property (p_full_drop) else $error("full buffer overrun");

  // the length fixed at the token holds to the packet end
  property p_hold_len;
    @(posedge clk_sys) disable iff (reset)
      (state_reg == FBP_SEND && !(take && pos_reg == len_reg)) |=> state_reg == FBP_SEND && $stable(len_reg);
  endproperty
  a_hold_len: assert property (p_hold_len) else $error("packet length changed while sending");

  // every end mark rides on a valid byte
  property p_last_valid;
    @(posedge clk_sys) disable iff (reset) tx_last |-> tx_valid;
  endproperty
  a_last_valid: assert property (p_last_valid) else $error("end mark without byte");

  // each byte sent from the buffer advances the read side by one
  property p_res_order;
    @(posedge clk_sys) disable iff (reset)
      pop |=> rd_reg == AW'($past(rd_reg) + 1'b1);
  endproperty
  a_res_order: assert property (p_res_order) else $error("result order broken");
endmodule
`default_nettype wire

/* File: tb/fbp_usb_host_model.sv */
// model of the usb core polling the feedback endpoint
// assumes the assembler takes a byte on each edge with tx_ready high
`timescale 1ns/1ns
`default_nettype none
module fbp_usb_host_model (
  input  wire logic       clk_sys,     // system clock
  input  wire logic       reset,       // async reset, active high
  input  wire logic       poll,        // start one IN transaction
  input  wire logic [3:0] poll_ep,     // endpoint of that transaction
  input  wire logic       slow,        // stall every other cycle
  output logic            in_req,      // token pulse
  output logic [3:0]      in_ep,       // token endpoint
  output logic            tx_ready,    // byte acceptance
  input  wire logic       tx_valid,    // byte from assembler
  input  wire logic [7:0] tx_data,     // byte value
  input  wire logic       tx_last,     // end of packet
  input  wire logic       tx_zlp,      // zero length answer
  output logic [7:0]      pkt [32],    // captured packet
  output logic [5:0]      got,         // bytes captured
  output logic            done         // packet ended
);
  logic busy;                          // transaction open
  // ****************************************
  // token, acceptance and capture
  // ****************************************
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      in_req <= 1'b0;
      in_ep <= 4'h0;
      tx_ready <= 1'b0;
      busy <= 1'b0;
      got <= 6'h00;
      done <= 1'b0;
    end else begin
      in_req <= poll;                  // host polls when told
      in_ep <= poll ? poll_ep : ~in_ep; // endpoint only valid with token
      tx_ready <= busy & (~slow | ~tx_ready);
      if (poll) begin
        busy <= 1'b1;
        got <= 6'h00;
        done <= 1'b0;
      end
      if (tx_valid) begin
        pkt[got[4:0]] <= tx_data;
        got <= got + 6'h01;
      end
      if ((tx_valid & tx_last) | tx_zlp) begin
        done <= 1'b1;
        busy <= 1'b0;
        tx_ready <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/usb_status_feedback_packet_tb.sv */
// testbench for the feedback packet assembler
// assumes the host model in fbp_usb_host_model and a 20 MHz clock
`timescale 1ns/1ns
`default_nettype none
module usb_status_feedback_packet_tb;
  localparam logic [7:0] DETECT_CODE = 8'hA5; // detect byte value, arbitrary
  logic       clk_sys = 1'b0;   // system clock
  logic       reset = 1'b1;     // reset
  logic       poll = 1'b0;      // host start
  logic [3:0] poll_ep = 4'h1;   // host endpoint
  logic       slow = 1'b0;      // host stall mode
  logic       in_req;           // token
  logic [3:0] in_ep;            // token endpoint
  logic       tx_ready;         // acceptance
  logic       tx_valid;         // byte valid
  logic [7:0] tx_data;          // byte
  logic       tx_last;          // last byte
  logic       tx_zlp;           // zero length
  logic       result_push = 1'b0; // result event
  logic [7:0] result_code = 8'h00; // result value
  logic [4:0] result_count;     // results held
  logic [7:0] sv [16];          // state inputs by packet offset
  logic [7:0] pkt [32];         // captured packet
  logic [5:0] got;              // captured length
  logic       done;             // packet ended
  logic [7:0] exp_q [$];        // results expected, oldest first
  int         mismatches = 0;   // failed compares
  int         compares = 0;     // all compares
  int         zlps = 0;         // zero length answers seen
  // ****************************************
  // clock, design and host
  // ****************************************
  initial begin
    forever #25 clk_sys = ~clk_sys;
  end
  fbp_usb_host_model host (.clk_sys(clk_sys), .reset(reset), .poll(poll), .poll_ep(poll_ep), .slow(slow),
    .in_req(in_req), .in_ep(in_ep), .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_last(tx_last), .tx_zlp(tx_zlp), .pkt(pkt), .got(got), .done(done));
  fbp_feedback #(.DEPTH(16)) dut (.clk_sys(clk_sys), .reset(reset), .in_req(in_req), .in_ep(in_ep),
    .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_zlp(tx_zlp),
    .pullup_enable(sv[0][0]), .program_pulse_enable(sv[0][1]), .dynamic_pullup_enable(sv[0][2]),
    .bus_speed_code(sv[1]), .pullup_duration(sv[2]), .program_pulse_duration(sv[3]),
    .pulldown_slew_code(sv[4]), .write_one_low_time(sv[5]), .sample_offset_recovery(sv[6]),
    .pullup_active(sv[8][0]), .program_pulse_active(sv[8][1]), .high_voltage_present(sv[8][2]),
    .external_power_mode(sv[8][3]), .halted(sv[8][4]), .idle(sv[8][5]),
    .active_command_low(sv[9]), .active_command_high(sv[10]), .cmd_fill(sv[11]), .write_fill(sv[12]),
    .read_fill(sv[13]), .result_push(result_push), .result_code(result_code), .result_count(result_count));
  // count zero length answers; sixteen state bytes always go, so none may come
  always @(posedge clk_sys) begin
    if (tx_zlp !== 1'b0 && !reset) zlps++;
  end
  // ****************************************
  // helpers
  // ****************************************
  task automatic tick();
    @(posedge clk_sys);
    #2;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // state inputs from a seed, reserved input bits left set on purpose
  task automatic set_state(input logic [7:0] seed);
    for (int k = 0; k < 16; k++) sv[k] = seed + 8'(k * 17);
  endtask
  function automatic logic [7:0] exp_state(input int k);
    case (k)
      0: return sv[0] & 8'h07;              // three enables only
      7, 14, 15: return 8'h00;              // test bytes read zero
      8: return sv[8] & 8'h3F;              // six status flags only
      9, 10: return sv[8][5] ? 8'h00 : sv[k]; // command zero when idle
      default: return sv[k];                // settings and fills
    endcase
  endfunction
  // back-to-back result events, held by the device up to sixteen
  task automatic push_n(input int n, input logic [7:0] base);
    for (int i = 0; i < n; i++) begin
      tick();
      result_push = 1'b1;
      result_code = (i == 1) ? DETECT_CODE : base + 8'(i);
      if (exp_q.size() < 16) exp_q.push_back(result_code); // full buffer drops
    end
    tick();
    result_push = 1'b0;
  endtask
  task automatic do_poll(input logic [3:0] ep, input logic slw, input int wait_max);
    int t;
    t = 0;
    tick();
    poll = 1'b1;
    poll_ep = ep;
    slow = slw;
    tick();
    poll = 1'b0;
    while (!done && t < wait_max) begin
      tick();
      t++;
    end
    tick();
  endtask
  // whole packet: state section, results in push order, then emptied
  task automatic check_pkt();
    int n;
    n = 16 + exp_q.size();
    chk("length", {2'h0, got}, 8'(n));                     // short or full packet
    chk("ended", {7'h0, done}, 8'h01);                     // packet closed
    for (int k = 0; k < 16; k++) chk("state", pkt[k], exp_state(k)); // state leads
    for (int k = 16; k < n; k++) chk("result", pkt[k], exp_q.pop_front()); // order and scan
    chk("count after", {3'h0, result_count}, 8'h00);       // sent results removed
  endtask
  // ****************************************
  // tests
  // ****************************************
  initial begin
    set_state(8'h27);
    repeat (4) tick();
    reset = 1'b0;
    chk("count at reset", {3'h0, result_count}, 8'h00);    // no events held yet
    do_poll(4'h1, 1'b0, 200);
    check_pkt();                                           // idle, no results
    do_poll(4'h2, 1'b0, 40);
    chk("other endpoint", {2'h0, got}, 8'h00);             // no answer
    set_state(8'h13);
    push_n(3, 8'h01);
    chk("count", {3'h0, result_count}, 8'h03);             // events held
    do_poll(4'h1, 1'b1, 400);
    check_pkt();                                           // stalled host, busy device
    set_state(8'hC6);
    push_n(18, 8'h40);
    chk("count full", {3'h0, result_count}, 8'h10);        // capped at sixteen
    do_poll(4'h1, 1'b0, 200);
    check_pkt();                                           // full 32 bytes
    chk("zero length", 8'(zlps), 8'h00);                   // never a zero length answer
    wrap_up();
  end
  initial begin
    repeat (3000) @(posedge clk_sys);
    mismatches++;
    wrap_up();
  end
endmodule
`default_nettype wire
